//--- src/adc_i2c_pkg.sv
// Shared constants and types for the converter's two-wire register port.
// Assumes a single 25 MHz system clock; bus pins are sampled, never used as clocks.
package adc_i2c_pkg;

  // Bus addressing.
  localparam logic [6:0] BUS_ADDR_BASE = 7'h48;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;

  // Strap connection codes, equal to the low two address bits they select.
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_VDD = 2'h1;
  localparam logic [1:0] STRAP_SDA = 2'h2;
  localparam logic [1:0] STRAP_SCL = 2'h3;

  // Register select codes held in the pointer.
  localparam logic [1:0] SEL_RESULT = 2'h0;
  localparam logic [1:0] SEL_CONFIG = 2'h1;
  localparam logic [1:0] SEL_LOW = 2'h2;
  localparam logic [1:0] SEL_HIGH = 2'h3;

  // Reset values of the stored words.
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h8583;
  localparam logic [15:0] LOW_LIMIT_RESET = 16'h8000;
  localparam logic [15:0] HIGH_LIMIT_RESET = 16'h7ff0;
  localparam logic [15:0] ABSENT_WORD = 16'h0000;

  // Result format: 12-bit code left-justified, low nibble zero.
  localparam logic [11:0] CODE_POS_MAX = 12'h7ff;
  localparam logic [11:0] CODE_NEG_MIN = 12'h800;
  localparam logic [3:0] RESULT_PAD = 4'h0;
  localparam logic signed [15:0] SAMPLE_POS_MAX = 16'sh07ff;
  localparam logic signed [15:0] SAMPLE_NEG_MIN = 16'shf800;

  // Bit counting and idle line levels {strap, sda, scl}.
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] LINES_IDLE = 3'h3;

  // Protocol engine states.
  typedef enum {ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_GC_CMD, ST_ACK, ST_TX, ST_TX_ACK}
    link_state_t;

endpackage : adc_i2c_pkg

//--- src/i2c_pin_sync.sv
// Pin synchroniser and bus event detector for the two-wire port.
// Assumes asynchronous pins; each passes two flip-flops before any logic reads it.
`timescale 1ns/10ps
module i2c_pin_sync (
  // Clock and reset.
  input logic clock,
  input logic sys_rst,
  // Raw pins.
  input logic sclPin,
  input logic sdaPin,
  input logic strapPin,
  // Synchronised levels and events.
  output logic sclLevel,
  output logic sdaLevel,
  output logic strapLevel,
  output logic sclRise,
  output logic sclFall,
  output logic startSeen,
  output logic stopSeen
);

  logic [2:0] meta_reg, meta_next;
  logic [2:0] sync_reg, sync_next;
  logic [2:0] last_reg, last_next;

  // The first stage feeds only the second; edges compare second and third.
  always_comb begin
    meta_next = {strapPin, sdaPin, sclPin};
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  // Stage registers start at idle bus levels so release makes no false edge.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= adc_i2c_pkg::LINES_IDLE;
      sync_reg <= adc_i2c_pkg::LINES_IDLE;
      last_reg <= adc_i2c_pkg::LINES_IDLE;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  // Levels and one-cycle events; START and STOP are data edges while the clock is high.
  assign sclLevel = sync_reg[0];
  assign sdaLevel = sync_reg[1];
  assign strapLevel = sync_reg[2];
  assign sclRise = sync_reg[0] & ~last_reg[0];
  assign sclFall = ~sync_reg[0] & last_reg[0];
  assign startSeen = sync_reg[0] & last_reg[0] & ~sync_reg[1] & last_reg[1];
  assign stopSeen = sync_reg[0] & last_reg[0] & sync_reg[1] & ~last_reg[1];

endmodule : i2c_pin_sync

//--- src/adc_i2c_register_port.sv
// Two-wire slave register port of a small data converter: pointer, result,
// configuration and limit words, plus general-call reset.
// Assumes a master-driven bus clock far slower than the 25 MHz system clock.
//
// Notes on behaviour
// - Address byte with read bit high places the device in transmit mode.
// - Transmit sends selected register upper byte, then lower; master acknowledges each.
// - Master nack, START or STOP ends a read; device releases the data line.
// - First byte after acknowledged write address loads the pointer and is acknowledged.
// - Pointer select bits persist and steer every later read until rewritten or cleared by general call.
// - Select codes: 00 result, 01 config, 10 low limit, 11 high limit.
// - Results are 12-bit two's complement, left-justified in a 16-bit word.
// - Results clip at largest positive and most negative codes.
// - Result reads zero from reset until first conversion, then holds latest until a general-call reset clears it to zero.
// - Result bits 15:4 carry the code; bits 3:0 always read zero.
// - Limit registers exist only on variants with the comparator.
// - Two data bytes after the pointer go to the selected config or limit register, upper first; writes with select 00 are dropped.
// - Strap connection (ground, supply, data, clock) selects one of four addresses.
// - General call acknowledged; second byte 06h resets registers and powers down.
`timescale 1ns/10ps
module adc_i2c_register_port #(
  parameter bit HAS_COMPARATOR = 1'b1
) (
  // Clock and reset.
  input logic clock,
  input logic sys_rst,
  // Bus pins; data is open drain.
  input logic sclPin,
  input logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Address strap pin.
  input logic strapPin,
  // Converter side.
  input logic convDone,
  input logic signed [15:0] rawSample,
  output logic [15:0] configWord,
  output logic [15:0] lowLimitWord,
  output logic [15:0] highLimitWord,
  output logic [1:0] pointerSel,
  output logic powerDownPulse
);

  logic sclLevel, sdaLevel, strapLevel, sclRise, sclFall, startSeen, stopSeen;
  adc_i2c_pkg::link_state_t state_reg, state_next, retState_reg, retState_next;
  logic [2:0] bitCnt_reg, bitCnt_next;
  logic [7:0] rxShift_reg, rxShift_next, txShift_reg, txShift_next, wrHi_reg, wrHi_next;
  logic [15:0] txWord_reg, txWord_next;
  logic txLow_reg, txLow_next, ackPhase_reg, ackPhase_next, wrIdx_reg, wrIdx_next;
  logic sdaOe_reg, sdaOe_next, gcPulse_reg, gcPulse_next;
  logic [1:0] pointer_reg, pointer_next;
  logic strapA_reg, strapA_next, strapB_reg, strapB_next;
  logic [15:0] result_reg, result_next, config_reg, config_next;
  logic [15:0] lowLimit_reg, lowLimit_next, highLimit_reg, highLimit_next;
  logic [7:0] rxByte;
  logic [6:0] devAddr;
  logic [15:0] wrWord;
  logic wrCommit, gcHit;

  // Maps the strap level seen in the two telltale bus phases to a connection code.
  function automatic logic [1:0] strap_code(input logic sclHighSeen, input logic sdaHighSeen);
    if (!sclHighSeen && !sdaHighSeen) strap_code = adc_i2c_pkg::STRAP_GND;
    else if (sclHighSeen && sdaHighSeen) strap_code = adc_i2c_pkg::STRAP_VDD;
    else if (sdaHighSeen) strap_code = adc_i2c_pkg::STRAP_SDA;
    else strap_code = adc_i2c_pkg::STRAP_SCL;
  endfunction : strap_code

  // Clips a raw sample into the 12-bit code range.
  function automatic logic [11:0] clip_sample(input logic signed [15:0] s);
    if (s > adc_i2c_pkg::SAMPLE_POS_MAX) clip_sample = adc_i2c_pkg::CODE_POS_MAX;
    else if (s < adc_i2c_pkg::SAMPLE_NEG_MIN) clip_sample = adc_i2c_pkg::CODE_NEG_MIN;
    else clip_sample = s[11:0];
  endfunction : clip_sample

  // Returns the word that the select code reads; absent limits read zero.
  function automatic logic [15:0] read_word(input logic [1:0] sel, input logic [15:0] res,
                                            input logic [15:0] cfg, input logic [15:0] lo,
                                            input logic [15:0] hi);
    case (sel)
      adc_i2c_pkg::SEL_RESULT: read_word = res;
      adc_i2c_pkg::SEL_CONFIG: read_word = cfg;
      adc_i2c_pkg::SEL_LOW: read_word = HAS_COMPARATOR ? lo : adc_i2c_pkg::ABSENT_WORD;
      default: read_word = HAS_COMPARATOR ? hi : adc_i2c_pkg::ABSENT_WORD;
    endcase
  endfunction : read_word

  i2c_pin_sync i2c_pin_sync_i (
    .clock(clock),
    .sys_rst(sys_rst),
    .sclPin(sclPin),
    .sdaPin(sdaIn),
    .strapPin(strapPin),
    .sclLevel(sclLevel),
    .sdaLevel(sdaLevel),
    .strapLevel(strapLevel),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startSeen(startSeen),
    .stopSeen(stopSeen)
  );

  // Byte being completed, strap-selected address and the pending write word.
  assign rxByte = {rxShift_reg[6:0], sdaLevel};
  assign devAddr = adc_i2c_pkg::BUS_ADDR_BASE | {5'h00, strap_code(strapA_reg, strapB_reg)};
  assign wrWord = {wrHi_reg, rxByte};

  // Strap watch: clock high with data low, and clock low with data high, tell the four apart.
  always_comb begin
    strapA_next = strapA_reg;
    strapB_next = strapB_reg;
    if (sclLevel && !sdaLevel) strapA_next = strapLevel;
    if (!sclLevel && sdaLevel) strapB_next = strapLevel;
  end

  // Protocol engine: shifts bytes, acknowledges, drives read data.
  always_comb begin
    state_next = state_reg;
    retState_next = retState_reg;
    bitCnt_next = bitCnt_reg;
    rxShift_next = rxShift_reg;
    txShift_next = txShift_reg;
    txWord_next = txWord_reg;
    txLow_next = txLow_reg;
    ackPhase_next = ackPhase_reg;
    sdaOe_next = sdaOe_reg;
    wrHi_next = wrHi_reg;
    wrIdx_next = wrIdx_reg;
    pointer_next = pointer_reg;
    wrCommit = 1'b0;
    gcHit = 1'b0;
    if (stopSeen) begin
      state_next = adc_i2c_pkg::ST_IDLE;
      sdaOe_next = 1'b0;
    end else if (startSeen) begin
      state_next = adc_i2c_pkg::ST_ADDR;
      bitCnt_next = 3'h0;
      sdaOe_next = 1'b0;
    end else begin
      case (state_reg)
        adc_i2c_pkg::ST_ADDR, adc_i2c_pkg::ST_PTR, adc_i2c_pkg::ST_WDATA,
        adc_i2c_pkg::ST_GC_CMD: begin
          if (sclRise) begin
            rxShift_next = rxByte;
            bitCnt_next = bitCnt_reg + 3'h1;
            if (bitCnt_reg == adc_i2c_pkg::BIT_LAST) begin
              state_next = adc_i2c_pkg::ST_ACK;
              ackPhase_next = 1'b0;
              case (state_reg)
                adc_i2c_pkg::ST_ADDR: begin
                  if (rxByte[7:1] == devAddr) begin
                    // Snapshot the selected word so both bytes come from one value.
                    retState_next = rxByte[0] ? adc_i2c_pkg::ST_TX : adc_i2c_pkg::ST_PTR;
                    txWord_next = read_word(pointer_reg, result_reg, config_reg,
                                            lowLimit_reg, highLimit_reg);
                  end else if (rxByte[7:1] == adc_i2c_pkg::GENERAL_CALL_ADDR && !rxByte[0]) begin
                    retState_next = adc_i2c_pkg::ST_GC_CMD;
                  end else begin
                    state_next = adc_i2c_pkg::ST_IDLE;
                  end
                end
                adc_i2c_pkg::ST_PTR: begin
                  pointer_next = rxByte[1:0];
                  retState_next = adc_i2c_pkg::ST_WDATA;
                  wrIdx_next = 1'b0;
                end
                adc_i2c_pkg::ST_WDATA: begin
                  // Upper byte is held; the lower byte commits the whole word.
                  if (!wrIdx_reg) wrHi_next = rxByte;
                  else wrCommit = 1'b1;
                  wrIdx_next = ~wrIdx_reg;
                  retState_next = adc_i2c_pkg::ST_WDATA;
                end
                default: begin
                  if (rxByte == adc_i2c_pkg::GC_RESET_CMD) begin
                    gcHit = 1'b1;
                    pointer_next = adc_i2c_pkg::SEL_RESULT;
                    retState_next = adc_i2c_pkg::ST_IDLE;
                  end else begin
                    state_next = adc_i2c_pkg::ST_IDLE;
                  end
                end
              endcase
            end
          end
        end
        adc_i2c_pkg::ST_ACK: begin
          // First fall pulls data low for the acknowledge; the second releases it, or drives the first read bit.
          if (sclFall) begin
            if (!ackPhase_reg) begin
              sdaOe_next = 1'b1;
              ackPhase_next = 1'b1;
            end else begin
              state_next = retState_reg;
              bitCnt_next = 3'h0;
              sdaOe_next = 1'b0;
              if (retState_reg == adc_i2c_pkg::ST_TX) begin
                sdaOe_next = ~txWord_reg[15];
                txShift_next = {txWord_reg[14:8], 1'b0};
                txLow_next = 1'b1;
              end
            end
          end
        end
        adc_i2c_pkg::ST_TX: begin
          if (sclFall) begin
            sdaOe_next = ~txShift_reg[7];
            txShift_next = {txShift_reg[6:0], 1'b0};
          end
          if (sclRise) begin
            bitCnt_next = bitCnt_reg + 3'h1;
            if (bitCnt_reg == adc_i2c_pkg::BIT_LAST) state_next = adc_i2c_pkg::ST_TX_ACK;
          end
        end
        adc_i2c_pkg::ST_TX_ACK: begin
          if (sclFall) sdaOe_next = 1'b0;
          if (sclRise) begin
            if (!sdaLevel) begin
              // Acknowledged: lower byte next, then the word repeats.
              state_next = adc_i2c_pkg::ST_TX;
              bitCnt_next = 3'h0;
              txShift_next = txLow_reg ? txWord_reg[7:0] : txWord_reg[15:8];
              txLow_next = ~txLow_reg;
            end else begin
              state_next = adc_i2c_pkg::ST_IDLE;
            end
          end
        end
        adc_i2c_pkg::ST_IDLE: begin
          sdaOe_next = 1'b0;
        end
        default: begin
          state_next = adc_i2c_pkg::ST_IDLE;
          sdaOe_next = 1'b0;
        end
      endcase
    end
  end

  // Stored words: written over the bus, reset by general call, result from the converter.
  always_comb begin
    result_next = result_reg;
    config_next = config_reg;
    lowLimit_next = lowLimit_reg;
    highLimit_next = highLimit_reg;
    gcPulse_next = gcHit;
    if (gcHit) begin
      result_next = adc_i2c_pkg::RESULT_RESET;
      config_next = adc_i2c_pkg::CONFIG_RESET;
      lowLimit_next = adc_i2c_pkg::LOW_LIMIT_RESET;
      highLimit_next = adc_i2c_pkg::HIGH_LIMIT_RESET;
    end
    if (wrCommit) begin
      case (pointer_reg)
        adc_i2c_pkg::SEL_CONFIG: config_next = wrWord;
        adc_i2c_pkg::SEL_LOW: if (HAS_COMPARATOR) lowLimit_next = wrWord;
        adc_i2c_pkg::SEL_HIGH: if (HAS_COMPARATOR) highLimit_next = wrWord;
        default: result_next = result_reg;
      endcase
    end
    // A finishing conversion wins over a general-call clear in the same cycle.
    if (convDone) result_next = {clip_sample(rawSample), adc_i2c_pkg::RESULT_PAD};
  end

  // State registers.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= adc_i2c_pkg::ST_IDLE;
      retState_reg <= adc_i2c_pkg::ST_IDLE;
      bitCnt_reg <= 3'h0;
      rxShift_reg <= 8'h00;
      txShift_reg <= 8'h00;
      txWord_reg <= 16'h0000;
      txLow_reg <= 1'b0;
      ackPhase_reg <= 1'b0;
      sdaOe_reg <= 1'b0;
      wrHi_reg <= 8'h00;
      wrIdx_reg <= 1'b0;
      pointer_reg <= adc_i2c_pkg::SEL_RESULT;
      strapA_reg <= 1'b0;
      strapB_reg <= 1'b0;
      result_reg <= adc_i2c_pkg::RESULT_RESET;
      config_reg <= adc_i2c_pkg::CONFIG_RESET;
      lowLimit_reg <= adc_i2c_pkg::LOW_LIMIT_RESET;
      highLimit_reg <= adc_i2c_pkg::HIGH_LIMIT_RESET;
      gcPulse_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      retState_reg <= retState_next;
      bitCnt_reg <= bitCnt_next;
      rxShift_reg <= rxShift_next;
      txShift_reg <= txShift_next;
      txWord_reg <= txWord_next;
      txLow_reg <= txLow_next;
      ackPhase_reg <= ackPhase_next;
      sdaOe_reg <= sdaOe_next;
      wrHi_reg <= wrHi_next;
      wrIdx_reg <= wrIdx_next;
      pointer_reg <= pointer_next;
      strapA_reg <= strapA_next;
      strapB_reg <= strapB_next;
      result_reg <= result_next;
      config_reg <= config_next;
      lowLimit_reg <= lowLimit_next;
      highLimit_reg <= highLimit_next;
      gcPulse_reg <= gcPulse_next;
    end
  end

  // Outputs; the data pin only ever pulls low.
  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_reg;
  assign configWord = config_reg;
  assign lowLimitWord = lowLimit_reg;
  assign highLimitWord = highLimit_reg;
  assign pointerSel = pointer_reg;
  assign powerDownPulse = gcPulse_reg;

  // Checks on the result word, pointer, config writes, bus release and general call.
  property p_result_pad;
    @(posedge clock) disable iff (sys_rst) result_reg[3:0] == adc_i2c_pkg::RESULT_PAD;
  endproperty
  a_result_pad: assert property (p_result_pad) else $error("result low nibble not zero");

  property p_clip_pos;
    @(posedge clock) disable iff (sys_rst) convDone && rawSample > adc_i2c_pkg::SAMPLE_POS_MAX
      |=> result_reg == {adc_i2c_pkg::CODE_POS_MAX, adc_i2c_pkg::RESULT_PAD};
  endproperty
  a_clip_pos: assert property (p_clip_pos) else $error("positive clip code wrong");

  property p_clip_neg;
    @(posedge clock) disable iff (sys_rst) convDone && rawSample < adc_i2c_pkg::SAMPLE_NEG_MIN
      |=> result_reg == {adc_i2c_pkg::CODE_NEG_MIN, adc_i2c_pkg::RESULT_PAD};
  endproperty
  a_clip_neg: assert property (p_clip_neg) else $error("negative clip code wrong");

  property p_result_hold;
    @(posedge clock) disable iff (sys_rst) !convDone && !gcHit |=> $stable(result_reg);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed unprompted");

  property p_pointer_hold;
    @(posedge clock) disable iff (sys_rst)
      !(state_reg == adc_i2c_pkg::ST_PTR && sclRise) && !gcHit |=> $stable(pointer_reg);
  endproperty
  a_pointer_hold: assert property (p_pointer_hold) else $error("pointer changed unprompted");

  property p_stop_release;
    @(posedge clock) disable iff (sys_rst) stopSeen |=> !sdaOe_reg [*2];
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("data held after stop");

  property p_addr_miss;
    @(posedge clock) disable iff (sys_rst)
      state_reg == adc_i2c_pkg::ST_ADDR && sclRise && bitCnt_reg == adc_i2c_pkg::BIT_LAST &&
      rxByte[7:1] != devAddr && rxByte[7:1] != adc_i2c_pkg::GENERAL_CALL_ADDR && !stopSeen
      |=> state_reg == adc_i2c_pkg::ST_IDLE && !sdaOe_reg;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address acknowledged");

  property p_gc_reset;
    @(posedge clock) disable iff (sys_rst) gcHit && !convDone
      |=> result_reg == adc_i2c_pkg::RESULT_RESET && pointer_reg == adc_i2c_pkg::SEL_RESULT
          && config_reg == adc_i2c_pkg::CONFIG_RESET && powerDownPulse;
  endproperty
  a_gc_reset: assert property (p_gc_reset) else $error("general call reset incomplete");

  property p_tx_nack;
    @(posedge clock) disable iff (sys_rst)
      state_reg == adc_i2c_pkg::ST_TX_ACK && sclRise && sdaLevel
      |=> state_reg == adc_i2c_pkg::ST_IDLE ##1 !sdaOe_reg;
  endproperty
  a_tx_nack: assert property (p_tx_nack) else $error("transmit continued after nack");

  property p_write_config;
    @(posedge clock) disable iff (sys_rst)
      wrCommit && pointer_reg == adc_i2c_pkg::SEL_CONFIG |=> config_reg == $past(wrWord);
  endproperty
  a_write_config: assert property (p_write_config) else $error("config write lost");

endmodule : adc_i2c_register_port

//--- sim/i2c_master_model.sv
// Behavioural two-wire bus master that drives the register port's bus pins.
// Assumes the bench resolves the open-drain data wire; bus period is 8 clocks.
`timescale 1ns/10ps
module i2c_master_model (
  // Timing reference.
  input wire logic clock,
  // Resolved data wire.
  input wire logic sdaLine,
  // Driven bus clock and data pull-down.
  output logic sclDrv,
  output logic sdaPull
);
  // Idle bus: clock high, data released to its pull-up.
  initial begin
    sclDrv = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  // One bit: data set in the low phase, sampled at the end of the high phase.
  task automatic bitOut(input logic b, output logic r);
    sclDrv = 1'b0;
    tick(2);
    sdaPull = !b;
    tick(2);
    sclDrv = 1'b1;
    tick(4);
    r = sdaLine;
  endtask : bitOut
  // Start or repeated start: data falls while the clock is high.
  task automatic startC();
    sclDrv = 1'b0;
    tick(2);
    sdaPull = 1'b0;
    tick(2);
    sclDrv = 1'b1;
    tick(4);
    sdaPull = 1'b1;
    tick(4);
  endtask : startC
  // Stop: data rises while the clock is high, which also ends any read.
  task automatic stopC();
    sclDrv = 1'b0;
    tick(2);
    sdaPull = 1'b1;
    tick(2);
    sclDrv = 1'b1;
    tick(4);
    sdaPull = 1'b0;
    tick(4);
  endtask : stopC
  // Byte out, most significant bit first, then the slave's acknowledge.
  task automatic writeByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitOut(d[i], r);
    end
    bitOut(1'b1, r);
    ack = !r;
  endtask : writeByte
  // Byte in; the master acknowledges or withholds it to end the read.
  task automatic readByte(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitOut(1'b1, r);
      d[i] = r;
    end
    bitOut(!ackIt, r);
  endtask : readByte
endmodule : i2c_master_model

//--- sim/adc_i2c_register_port_test.sv
// Self-checking bench for the converter's two-wire register port.
// Assumes the master model above and a strap pin driven by the bench.
`timescale 1ns/10ps
module adc_i2c_register_port_test;
  logic clock = 1'b0, sys_rst = 1'b1, convDone = 1'b0, strapPin = 1'b0, pdSeen = 1'b0;
  logic signed [15:0] rawSample = 16'sh0000;
  logic sclDrv, sdaPull, sdaOe, sdaOut, powerDownPulse, ack;
  logic [15:0] configWord, lowLimitWord, highLimitWord, w;
  logic [1:0] pointerSel;
  logic [6:0] devAddr = adc_i2c_pkg::BUS_ADDR_BASE;
  logic sdaOeLite;
  logic [15:0] lowLimitLite;
  int n_errors = 0, total_checks = 0;
  wire sdaLine = !(sdaPull || (sdaOe && !sdaOut) || sdaOeLite);
  i2c_master_model i2c_master_model_i (.clock(clock), .sdaLine(sdaLine), .sclDrv(sclDrv),
    .sdaPull(sdaPull));
  adc_i2c_register_port adc_i2c_register_port_i (.clock(clock), .sys_rst(sys_rst),
    .sclPin(sclDrv), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .strapPin(strapPin),
    .convDone(convDone), .rawSample(rawSample), .configWord(configWord),
    .lowLimitWord(lowLimitWord), .highLimitWord(highLimitWord), .pointerSel(pointerSel),
    .powerDownPulse(powerDownPulse));
  // Variant without limit registers on the same bus, strapped to the clock wire.
  adc_i2c_register_port #(.HAS_COMPARATOR(1'b0)) adc_i2c_register_port_lite_i (
    .clock(clock), .sys_rst(sys_rst), .sclPin(sclDrv), .sdaIn(sdaLine), .sdaOut(),
    .sdaOe(sdaOeLite), .strapPin(sclDrv), .convDone(1'b0), .rawSample(16'sh0000),
    .configWord(), .lowLimitWord(lowLimitLite), .highLimitWord(), .pointerSel(),
    .powerDownPulse());
  // Clock and a latch for the one-cycle power-down pulse.
  initial begin
    forever #20 clock = !clock;
  end
  always @(posedge clock) if (powerDownPulse === 1'b1) pdSeen <= 1'b1;
  task automatic checkWord(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : checkWord
  task automatic checkBit(input logic got, input logic exp);
    checkWord({15'h0000, got}, {15'h0000, exp});
  endtask : checkBit
  // Pointer byte, then optional data pair, each byte acknowledged.
  task automatic wrReg(input logic [1:0] sel, input logic withData, input logic [15:0] d);
    i2c_master_model_i.startC();
    i2c_master_model_i.writeByte({devAddr, 1'b0}, ack);
    checkBit(ack, 1'b1);
    i2c_master_model_i.writeByte({6'h00, sel}, ack);
    checkBit(ack, 1'b1);
    if (withData) begin
      i2c_master_model_i.writeByte(d[15:8], ack);
      checkBit(ack, 1'b1);
      i2c_master_model_i.writeByte(d[7:0], ack);
      checkBit(ack, 1'b1);
    end
    i2c_master_model_i.stopC();
  endtask : wrReg
  task automatic rdWord(input logic [15:0] exp);
    i2c_master_model_i.startC();
    i2c_master_model_i.writeByte({devAddr, 1'b1}, ack);
    checkBit(ack, 1'b1);
    i2c_master_model_i.readByte(1'b1, w[15:8]);
    i2c_master_model_i.readByte(1'b0, w[7:0]);
    i2c_master_model_i.stopC();
    checkWord(w, exp);
  endtask : rdWord
  // Reset values at the outputs and a read of the cleared result word.
  task automatic test_reset();
    checkWord(configWord, adc_i2c_pkg::CONFIG_RESET);
    checkBit(pointerSel == 2'h0, 1'b1);
    rdWord(16'h0000);
  endtask : test_reset
  // Select codes 01 to 11 are written, then each read back twice after a pointer-only write.
  task automatic test_regs();
    for (int s = 1; s < 4; s++) begin
      wrReg(s[1:0], 1'b1, 16'ha5c0 + 16'(s));
      checkBit(pointerSel === s[1:0], 1'b1);
      wrReg(s[1:0], 1'b0, 16'h0000);
      rdWord(16'ha5c0 + 16'(s));
      rdWord(16'ha5c0 + 16'(s));
    end
    checkWord(configWord, 16'ha5c1);
    checkWord(lowLimitWord, 16'ha5c2);
    checkWord(highLimitWord, 16'ha5c3);
  endtask : test_regs
  // In-range, clipped positive and clipped negative conversions.
  task automatic test_conv();
    logic [15:0] raw[3] = '{16'h0123, 16'h1000, 16'hf000};
    logic [15:0] exp[3] = '{16'h1230, 16'h7ff0, 16'h8000};
    wrReg(2'h0, 1'b0, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      @(negedge clock) rawSample = raw[i];
      convDone = 1'b1;
      @(negedge clock) convDone = 1'b0;
      rdWord(exp[i]);
    end
  endtask : test_conv
  // Early nack after the upper byte releases the data line.
  task automatic test_nack();
    i2c_master_model_i.startC();
    i2c_master_model_i.writeByte({devAddr, 1'b1}, ack);
    i2c_master_model_i.readByte(1'b0, w[15:8]);
    checkWord({w[15:8], 8'h00}, 16'h8000);
    i2c_master_model_i.tick(8);
    checkBit(sdaOe, 1'b0);
    i2c_master_model_i.stopC();
  endtask : test_nack
  // The variant without a comparator ignores limit writes and reads them as zero.
  task automatic test_absent();
    devAddr = adc_i2c_pkg::BUS_ADDR_BASE | 7'h03;
    wrReg(2'h2, 1'b1, 16'h1234);
    rdWord(16'h0000);
    checkWord(lowLimitLite, adc_i2c_pkg::LOW_LIMIT_RESET);
    devAddr = adc_i2c_pkg::BUS_ADDR_BASE;
  endtask : test_absent
  // General call reset, then address matching of two addresses with the strap held high.
  task automatic test_addr();
    i2c_master_model_i.startC();
    i2c_master_model_i.writeByte(8'h00, ack);
    checkBit(ack, 1'b1);
    i2c_master_model_i.writeByte(adc_i2c_pkg::GC_RESET_CMD, ack);
    i2c_master_model_i.stopC();
    checkBit(pdSeen, 1'b1);
    checkWord(configWord, adc_i2c_pkg::CONFIG_RESET);
    strapPin = 1'b1;
    for (int a = 0; a < 2; a++) begin
      i2c_master_model_i.startC();
      i2c_master_model_i.writeByte({7'h48 + 7'(a), 1'b0}, ack);
      checkBit(ack, a == 1);
      i2c_master_model_i.stopC();
    end
  endtask : test_addr
  task automatic final_report();
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  initial begin
    #2_000_000;
    n_errors++;
    final_report();
  end
  initial begin
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    test_reset();
    test_regs();
    test_conv();
    test_nack();
    test_absent();
    test_addr();
    final_report();
  end
endmodule : adc_i2c_register_port_test
